// ===== design/pcsps_phy_side.sv
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/10ps

module pcsps_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_check
    $error("fifo depth must be a power of two");
  end

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } pcsps_fifo_state_t;

  pcsps_fifo_state_t st;
  pcsps_fifo_state_t next_st;
  logic              full;
  logic              empty;

  assign full     = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
  assign empty    = (st.wp == st.rp);
  assign wr_ready = ~full;
  assign rd_valid = ~empty;
  assign rd_data  = st.mem[st.rp[AW-1:0]];

  always_comb
  begin
    next_st = st;
    if (wr_valid && !full)
    begin
      next_st.mem[st.wp[AW-1:0]] = wr_data;
      next_st.wp = st.wp + 1'b1;
    end
    if (rd_ready && !empty)
      next_st.rp = st.rp + 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end
endmodule

// Function
// - drive a reset output for the transceiver receive path only
// - drive a separate reset output for the transceiver transmit path only
// - hold transceiver in reset while the lock input is low
// - transceiver mode runs all logic on the single core clock
// - alignment enable output lets the transceiver realign to commas
// - ten-bit mode runs all logic on the same single core clock
// - ten-bit mode sends one 10-bit code group each core clock
// - lock-to-reference output is held low always
// - wrap output high selects external loopback, low normal operation
// - capture even symbol on even clock, odd symbol on odd clock
// - comma detect enable is high while sync engine is lost in ten-bit mode
module pcsps_phy_side #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire pcsps_pkg::pcsps_wb_req_t wb_req,
  output logic                        wb_ack_o,
  output logic [31:0]                 wb_dat_o,
  input  wire logic                   clock_locked,
  input  wire pcsps_pkg::pcsps_xrx_t  xcvr_rx,
  output pcsps_pkg::pcsps_xtx_t       xcvr_tx,
  output logic                        xcvr_rx_reset,
  output logic                        xcvr_tx_reset,
  output logic                        enable_align,
  output logic                        powerdown,
  output logic [9:0]                  tbi_tx_group,
  output logic                        lock_to_reference,
  output logic                        wrap,
  output logic                        comma_detect_enable,
  input  wire logic                   recovered_clock_even,
  input  wire logic                   recovered_clock_odd,
  input  wire logic [9:0]             receive_symbol_even,
  input  wire logic [9:0]             receive_symbol_odd
);
  import pcsps_pkg::*;

  typedef struct packed
  {
    logic        lock_s1;
    logic        lock_s2;
    logic [2:0]  ce_s;
    logic [2:0]  co_s;
    logic [9:0]  se_s1;
    logic [9:0]  se_s2;
    logic [9:0]  so_s1;
    logic [9:0]  so_s2;
    logic        mode_tbi;
    logic        wrap_en;
    logic        sw_rx;
    logic        sw_tx;
    logic        pwr;
    logic        rx_rst;
    logic        tx_rst;
    pcsps_sync_t sync_st;
    logic [2:0]  cnt;
    logic        err_flag;
    logic        rx_new;
    logic [9:0]  rx_even;
    logic [9:0]  rx_odd;
    logic [8:0]  rx_byte;
    logic [9:0]  tx_grp;
    pcsps_xtx_t  tx_x;
    logic        align;
    logic        cdet;
    logic        loc_ref;
    logic        ack;
    logic [31:0] dat;
  } pcsps_state_t;

  pcsps_state_t st;
  pcsps_state_t next_st;

  logic       f_wr_valid;
  logic       f_wr_ready;
  logic       f_rd_valid;
  logic       f_rd_ready;
  logic [9:0] f_rd_data;
  logic       req;
  logic       tx_write;
  logic       ev;
  logic       ev_comma;
  logic       ev_err;
  logic       edge_even;
  logic       edge_odd;
  logic [9:0] tbi_sym;

  assign req      = wb_req.cyc && wb_req.stb && !st.ack;
  assign tx_write = req && wb_req.we && (wb_req.adr == REG_TXDATA);
  assign f_wr_valid = tx_write;
  assign f_rd_ready = !st.tx_rst && !st.pwr;

  pcsps_fifo #(
    .WIDTH (GROUP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .wr_valid (f_wr_valid),
    .wr_ready (f_wr_ready),
    .wr_data  (wb_req.dat[9:0]),
    .rd_valid (f_rd_valid),
    .rd_ready (f_rd_ready),
    .rd_data  (f_rd_data)
  );

  // recovered clock edges from synchronised samples
  assign edge_even = st.ce_s[1] && !st.ce_s[2];
  assign edge_odd  = st.co_s[1] && !st.co_s[2];

  assign tbi_sym  = edge_even ? st.se_s2 : st.so_s2;
  assign ev       = st.mode_tbi ? (edge_even || edge_odd) : !st.rx_rst;
  assign ev_comma = st.mode_tbi ? ((tbi_sym[9:3] == COMMA_PLUS) || (tbi_sym[9:3] == COMMA_MINUS))
                                : (xcvr_rx.charisk && (xcvr_rx.data == COMMA_BYTE));
  assign ev_err   = !st.mode_tbi && (xcvr_rx.disperr || xcvr_rx.notintable);

  always_comb
  begin
    next_st = st;
    // input synchronisers
    next_st.lock_s1 = clock_locked;
    next_st.lock_s2 = st.lock_s1;
    next_st.ce_s  = {st.ce_s[1:0], recovered_clock_even};
    next_st.co_s  = {st.co_s[1:0], recovered_clock_odd};
    next_st.se_s1 = receive_symbol_even;
    next_st.se_s2 = st.se_s1;
    next_st.so_s1 = receive_symbol_odd;
    next_st.so_s2 = st.so_s1;

    next_st.rx_rst = !st.lock_s2 || st.sw_rx;
    next_st.tx_rst = !st.lock_s2 || st.sw_tx;

    if (st.mode_tbi && edge_even)
      next_st.rx_even = st.se_s2;
    if (st.mode_tbi && edge_odd)
      next_st.rx_odd = st.so_s2;
    if (!st.mode_tbi && !st.rx_rst)
      next_st.rx_byte = {xcvr_rx.charisk, xcvr_rx.data};

    // sync engine
    if (st.rx_rst)
    begin
      next_st.sync_st = PCSPS_LOS;
      next_st.cnt     = '0;
    end
    else if (ev)
    begin
      unique case (st.sync_st)
        PCSPS_LOS:
        begin
          if (ev_comma)
          begin
            next_st.sync_st = PCSPS_ACQ;
            next_st.cnt     = 3'h1;
          end
        end
        PCSPS_ACQ:
        begin
          if (ev_err)
            next_st.sync_st = PCSPS_LOS;
          else if (ev_comma && st.cnt + 3'h1 == ACQ_COMMAS)
          begin
            next_st.sync_st = PCSPS_SYNC;
            next_st.cnt     = '0;
          end
          else if (ev_comma)
            next_st.cnt = st.cnt + 3'h1;
        end
        PCSPS_SYNC:
        begin
          if (ev_err && st.cnt + 3'h1 == LOSE_ERRORS)
          begin
            next_st.sync_st = PCSPS_LOS;
            next_st.cnt     = '0;
          end
          else if (ev_err)
            next_st.cnt = st.cnt + 3'h1;
          else if (ev_comma)
            next_st.cnt = '0;
        end
        default:
          next_st.sync_st = PCSPS_LOS;
      endcase
    end

    next_st.align = !st.mode_tbi && (next_st.sync_st == PCSPS_LOS);
    next_st.cdet  = st.mode_tbi && (next_st.sync_st == PCSPS_LOS);
    next_st.loc_ref = 1'b0;

    if (f_rd_ready && f_rd_valid)
    begin
      next_st.tx_grp = st.mode_tbi ? f_rd_data : IDLE_GROUP;
      next_st.tx_x   = st.mode_tbi ? {1'b1, COMMA_BYTE} : f_rd_data[8:0];
    end
    else
    begin
      next_st.tx_grp = IDLE_GROUP;
      next_st.tx_x   = {1'b1, COMMA_BYTE};
    end

    // wishbone slave, one cycle answer, stall on full fifo
    next_st.ack = req && (!tx_write || f_wr_ready);
    next_st.dat = ZERO_WORD;
    if (req && !wb_req.we)
    begin
      unique case (wb_req.adr)
        REG_CTRL:
        begin
          next_st.dat[CTRL_MODE_TBI] = st.mode_tbi;
          next_st.dat[CTRL_WRAP]     = st.wrap_en;
          next_st.dat[CTRL_SW_RX]    = st.sw_rx;
          next_st.dat[CTRL_SW_TX]    = st.sw_tx;
          next_st.dat[CTRL_PWRDN]    = st.pwr;
        end
        REG_STATUS:
        begin
          next_st.dat[ST_SYNC_LO +: 2] = st.sync_st;
          next_st.dat[ST_LOCK]   = st.lock_s2;
          next_st.dat[ST_FULL]   = !f_wr_ready;
          next_st.dat[ST_EMPTY]  = !f_rd_valid;
          next_st.dat[ST_ERR]    = st.err_flag;
          next_st.dat[ST_RX_NEW] = st.rx_new;
          next_st.dat[ST_RX_RST] = st.rx_rst;
          next_st.dat[ST_TX_RST] = st.tx_rst;
        end
        REG_RXDATA:
        begin
          next_st.dat = st.mode_tbi ? {12'h000, st.rx_odd, st.rx_even} : {23'h000000, st.rx_byte};
          next_st.rx_new = 1'b0;
        end
        default:
          next_st.dat = ZERO_WORD;
      endcase
    end
    if (req && wb_req.we && wb_req.sel[0])
    begin
      if (wb_req.adr == REG_CTRL)
      begin
        next_st.mode_tbi = wb_req.dat[CTRL_MODE_TBI];
        next_st.wrap_en  = wb_req.dat[CTRL_WRAP];
        next_st.sw_rx    = wb_req.dat[CTRL_SW_RX];
        next_st.sw_tx    = wb_req.dat[CTRL_SW_TX];
        next_st.pwr      = wb_req.dat[CTRL_PWRDN];
      end
      else if (wb_req.adr == REG_STATUS)
      begin
        if (wb_req.dat[ST_ERR])
          next_st.err_flag = 1'b0;
        if (wb_req.dat[ST_RX_NEW])
          next_st.rx_new = 1'b0;
      end
    end
    // sets win over clears
    if (ev && ev_err)
      next_st.err_flag = 1'b1;
    if (st.mode_tbi && (edge_even || edge_odd))
      next_st.rx_new = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st         <= '0;
      st.rx_rst  <= 1'b1;
      st.tx_rst  <= 1'b1;
      st.align   <= 1'b1;
      st.tx_grp  <= IDLE_GROUP;
      st.tx_x    <= {1'b1, COMMA_BYTE};
    end
    else
      st <= next_st;
  end

  assign wb_ack_o            = st.ack;
  assign wb_dat_o            = st.dat;
  assign xcvr_tx             = st.tx_x;
  assign xcvr_rx_reset       = st.rx_rst;
  assign xcvr_tx_reset       = st.tx_rst;
  assign enable_align        = st.align;
  assign powerdown           = st.pwr;
  assign tbi_tx_group        = st.tx_grp;
  assign lock_to_reference   = st.loc_ref;
  assign wrap                = st.wrap_en;
  assign comma_detect_enable = st.cdet;
endmodule

// ===== design/pcsps_pkg.sv
package pcsps_pkg;
  // register byte addresses
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_TXDATA = 4'h8;
  localparam logic [3:0] REG_RXDATA = 4'hc;
  // control fields
  localparam int CTRL_MODE_TBI = 0;
  localparam int CTRL_WRAP     = 1;
  localparam int CTRL_SW_RX    = 2;
  localparam int CTRL_SW_TX    = 3;
  localparam int CTRL_PWRDN    = 4;
  // status fields
  localparam int ST_SYNC_LO  = 0;
  localparam int ST_LOCK     = 2;
  localparam int ST_FULL     = 3;
  localparam int ST_EMPTY    = 4;
  localparam int ST_ERR      = 5;
  localparam int ST_RX_NEW   = 6;
  localparam int ST_RX_RST   = 7;
  localparam int ST_TX_RST   = 8;
  // code words
  localparam int           GROUP_W      = 10;
  localparam logic [7:0]   COMMA_BYTE   = 8'hbc;
  localparam logic [9:0]   IDLE_GROUP   = 10'h0fa;
  localparam logic [6:0]   COMMA_PLUS   = 7'h1f;
  localparam logic [6:0]   COMMA_MINUS  = 7'h60;
  // sync engine thresholds and the all-zero read data word
  localparam logic [2:0]   ACQ_COMMAS   = 3'h3;
  localparam logic [2:0]   LOSE_ERRORS  = 3'h4;
  localparam logic [31:0]  ZERO_WORD    = 32'h0000_0000;

  typedef enum logic [1:0]
  {
    PCSPS_LOS  = 2'b00,
    PCSPS_ACQ  = 2'b01,
    PCSPS_SYNC = 2'b10
  } pcsps_sync_t;

  typedef struct packed
  {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [3:0]  adr;
    logic [31:0] dat;
  } pcsps_wb_req_t;

  typedef struct packed
  {
    logic       charisk;
    logic       disperr;
    logic       notintable;
    logic [7:0] data;
  } pcsps_xrx_t;

  typedef struct packed
  {
    logic       charisk;
    logic [7:0] data;
  } pcsps_xtx_t;
endpackage

// ===== test/pcsps_phy_side_chk.sv
`timescale 1ns/10ps
module pcsps_phy_side_chk (
  input wire logic                     clock,
  input wire logic                     sys_rst,
  input wire pcsps_pkg::pcsps_wb_req_t wb_req,
  input wire logic                     wb_ack_o,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     clock_locked,
  input wire pcsps_pkg::pcsps_xtx_t    xcvr_tx,
  input wire logic                     xcvr_rx_reset,
  input wire logic                     xcvr_tx_reset,
  input wire logic                     enable_align,
  input wire logic [9:0]               tbi_tx_group,
  input wire logic                     lock_to_reference,
  input wire logic                     wrap,
  input wire logic                     comma_detect_enable
);
  import pcsps_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence lock_low;
    !clock_locked [*4];
  endsequence
  sequence ctrl_wr;
    wb_req.cyc && wb_req.stb && wb_req.we && wb_req.adr == REG_CTRL && wb_req.sel[0] && !wb_ack_o;
  endsequence
  a_rst_no_lock: assert property (lock_low |-> xcvr_rx_reset && xcvr_tx_reset)
    else $error("transceiver reset low without lock");
  a_ltr_low: assert property (!lock_to_reference)
    else $error("lock to reference high");
  a_wrap_ctrl: assert property (ctrl_wr |=> ##1 wrap == $past(wb_req.dat[1], 2))
    else $error("wrap differs from control write");
  a_ack_next: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o && wb_req.adr != REG_TXDATA |=> wb_ack_o)
    else $error("ack missing");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == ZERO_WORD)
    else $error("read data outside ack");
  a_tx_idle_rst: assert property (xcvr_tx_reset |=> tbi_tx_group == IDLE_GROUP && xcvr_tx == 9'h1bc)
    else $error("transmit not idle in reset");
  a_one_out: assert property (!(tbi_tx_group != IDLE_GROUP && xcvr_tx != 9'h1bc))
    else $error("both transmit outputs busy");
  a_align_lost: assert property (xcvr_rx_reset [*2] |=> enable_align || comma_detect_enable)
    else $error("no realign while lost");
  a_align_excl: assert property (!(enable_align && comma_detect_enable))
    else $error("both align enables high");
endmodule
bind pcsps_phy_side pcsps_phy_side_chk chk_u (.clock(clock), .sys_rst(sys_rst), .wb_req(wb_req),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .clock_locked(clock_locked), .xcvr_tx(xcvr_tx),
  .xcvr_rx_reset(xcvr_rx_reset), .xcvr_tx_reset(xcvr_tx_reset), .enable_align(enable_align),
  .tbi_tx_group(tbi_tx_group), .lock_to_reference(lock_to_reference), .wrap(wrap),
  .comma_detect_enable(comma_detect_enable));

// ===== test/pcsps_phy_side_tb_top.sv
`timescale 1ns/10ps
module pcsps_phy_side_tb_top;
  import pcsps_pkg::*;
  logic                 clock, sys_rst, wb_ack_o, clock_locked, rx_rst, tx_rst, align, cdet;
  logic                 rclk_e, rclk_o, run, pwr_o, wrap_o;
  pcsps_wb_req_t        wb_req;
  pcsps_xrx_t           xcvr_rx;
  pcsps_xtx_t           xcvr_tx;
  logic [31:0]          wb_dat_o, seed, r;
  logic [9:0]           tbi_g, sym_e, sym_o, ev_in, od_in;
  logic [31:0]          eq[$], mq[$];
  logic [9:0]           tq[$];
  int                   err_count, checked;

  pcsps_phy_side dut_u (.clock(clock), .sys_rst(sys_rst), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .clock_locked(clock_locked), .xcvr_rx(xcvr_rx), .xcvr_tx(xcvr_tx),
    .xcvr_rx_reset(rx_rst), .xcvr_tx_reset(tx_rst), .enable_align(align), .powerdown(pwr_o),
    .tbi_tx_group(tbi_g), .lock_to_reference(), .wrap(wrap_o), .comma_detect_enable(cdet),
    .recovered_clock_even(rclk_e), .recovered_clock_odd(rclk_o),
    .receive_symbol_even(sym_e), .receive_symbol_odd(sym_o));
  pcsps_serdes_model far_u (.run(run), .even_in(ev_in), .odd_in(od_in), .clk_e(rclk_e),
    .clk_o(rclk_o), .sym_e(sym_e), .sym_o(sym_o));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    wb_req <= '{1'b1, 1'b1, w, 4'hf, a, d};
    @(posedge clock);
    while (wb_ack_o !== 1'b1)
      @(posedge clock);
    wb_req <= '0;
  endtask

  task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e & m);
    mq.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  task stop_test();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // results are matched against the oldest note
  always @(posedge clock)
  begin
    if (sys_rst === 1'b0 && wb_ack_o === 1'b1 && wb_req.we === 1'b0)
      chk("rdata", wb_dat_o & mq.pop_front(), eq.pop_front());
    if (sys_rst === 1'b0 && tbi_g !== IDLE_GROUP)
      chk("tbi_tx", {22'h0, tbi_g}, {22'h0, tq.pop_front()});
    else if (sys_rst === 1'b0 && xcvr_tx !== 9'h1bc)
      chk("xcvr_tx", {23'h0, xcvr_tx}, {22'h0, tq.pop_front()});
  end

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial
  begin
    #200000;
    err_count++;
    stop_test();
  end

  initial
  begin
    {sys_rst, clock_locked, run, ev_in, od_in, seed} = {3'b100, 20'h0, 32'h5f};
    wb_req = '0;
    xcvr_rx = '0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    rd(REG_STATUS, 32'h190, 32'h19f);
    clock_locked <= 1'b1;
    repeat (6) @(posedge clock);
    rd(REG_STATUS, 32'h014, 32'h19c);
    rd(4'h2, 32'h0, 32'hffff_ffff);
    // fill while powered down, then drain in each mode
    for (int m = 1; m >= 0; m--)
    begin
      bus(1'b1, REG_CTRL, 32'h10 | 32'(3 * m));
      repeat (16)
      begin
        r = xs();
        tq.push_back(m ? {1'b1, r[8:0]} : {2'b00, r[7:0]});
        bus(1'b1, REG_TXDATA, {22'h0, tq[$]});
      end
      rd(REG_STATUS, 32'h08, 32'h18);
      chk("ctrl_out", {30'h0, wrap_o, pwr_o}, {30'h0, m[0], 1'b1});
      bus(1'b1, REG_CTRL, 32'(3 * m));
      repeat (30) @(posedge clock);
      rd(REG_STATUS, 32'h10, 32'h18);
    end
    bus(1'b1, REG_CTRL, 32'h1);
    {ev_in, od_in, run} <= {10'h0f8, 10'h0fc, 1'b1};
    repeat (40) @(posedge clock);
    rd(REG_STATUS, 32'h2, 32'h3);
    chk("cdet", {31'h0, cdet}, 32'h0);
    r = xs();
    {ev_in, od_in} <= {1'b1, r[8:0], 1'b1, r[18:10]};
    repeat (40) @(posedge clock);
    run <= 1'b0;
    repeat (10) @(posedge clock);
    rd(REG_RXDATA, {12'h0, 1'b1, r[18:10], 1'b1, r[8:0]}, 32'hffff_ffff);
    bus(1'b1, REG_CTRL, 32'hd);
    repeat (4) @(posedge clock);
    chk("cdet", {31'h0, cdet}, 32'h1);
    chk("sw_resets", {30'h0, rx_rst, tx_rst}, 32'h3);
    r = xs();
    xcvr_rx <= '{1'b1, 1'b0, 1'b0, {1'b0, r[6:0]}};
    bus(1'b1, REG_CTRL, 32'h0);
    repeat (4) @(posedge clock);
    rd(REG_RXDATA, {23'h0, 1'b1, 1'b0, r[6:0]}, 32'hffff_ffff);
    chk("align", {31'h0, align}, 32'h1);
    xcvr_rx.disperr <= 1'b1;
    repeat (2) @(posedge clock);
    xcvr_rx.disperr <= 1'b0;
    rd(REG_STATUS, 32'h20, 32'h20);
    bus(1'b1, REG_STATUS, 32'h20);
    rd(REG_STATUS, 32'h0, 32'h20);
    clock_locked <= 1'b0;
    repeat (6) @(posedge clock);
    chk("resets", {30'h0, rx_rst, tx_rst}, 32'h3);
    chk("txq", 32'(tq.size()), 32'h0);
    stop_test();
  end
endmodule

// ===== test/pcsps_serdes_model.sv
`timescale 1ns/10ps
module pcsps_serdes_model (
  input wire logic       run,
  input wire logic [9:0] even_in,
  input wire logic [9:0] odd_in,
  output logic           clk_e,
  output logic           clk_o,
  output logic [9:0]     sym_e,
  output logic [9:0]     sym_o
);
  initial
  begin
    {clk_e, clk_o, sym_e, sym_o} = 22'h0;
    forever
    begin
      if (run !== 1'b1)
      begin
        // clocks stand still, stale symbols inverted
        {clk_e, clk_o, sym_e, sym_o} = {2'b00, ~sym_e, ~sym_o};
        @(posedge run);
      end
      sym_e = even_in;
      #50 {clk_e, clk_o} = 2'b10;
      #50 sym_o = odd_in;
      #50 {clk_e, clk_o} = 2'b01;
      #50;
    end
  end
endmodule
